// ==== shared/crts_defines.vh ====
// Constants for the code reader trigger sequencer
// Function
// (R1) Triggers start readings only in monitor or run mode.
// (R2) One-shot rising edge starts one reading with current scene.
// (R3) Successful one-shot reading stops, then judgement is presented.
// (R4) Failed one-shot reading retries up to configured retry count.
// (R5) Continuous mode reads back to back while hold trigger asserted.
// (R6) Level mode repeats readings while held, stopping on success.
// (R7) Level mode without success outputs fail when hold trigger drops.
// (R8) Scene-switch trigger selects its configured scene, then reads.
// (R9) Result outputs driven only in run mode, never in monitor mode.
// (R10) Every executed reading produces one reading result; code reports only the last reading of a one-shot retry series or level run.
// (R11) Success sends decoded content over the serial link.
// (R12) Failure sends error codes over the serial link.
// (R13) All result outputs are deasserted after reset.
// (R14) Shutter command issued in step with one-shot trigger.
// (R15) Polarity selects judgement asserting on fail (default) or success.
// (R16) Scene per switch trigger is 0 to 9, default 0, level behaviour.
// (R17) Hold-read readings ignore the retry count.
// (R18) Busy during reading; further triggers ignored.
// (R19) Trigger inputs synchronised before edge or level detection.
`ifndef CRTS_DEFINES_VH
`define CRTS_DEFINES_VH

// ****************************************
// Register map (word offsets, 4-bit index)
// ****************************************
`define CRTS_ADDR_W 4
`define CRTS_REG_CTRL 4'h0
`define CRTS_REG_SCENE 4'h1
`define CRTS_REG_STATUS 4'h2
`define CRTS_REG_IRQ_STAT 4'h3
`define CRTS_REG_IRQ_MASK 4'h4
`define CRTS_REG_RESULT 4'h5

// ****************************************
// Control fields
// ****************************************
`define CRTS_CTRL_MODE_LO 0
`define CRTS_CTRL_MODE_HI 1
`define CRTS_CTRL_HOLD_LVL 2
`define CRTS_CTRL_POL_OK 3
`define CRTS_CTRL_RETRY_LO 4
`define CRTS_CTRL_RETRY_HI 7

// Operating modes
`define CRTS_MODE_SETUP 2'h0
`define CRTS_MODE_MON 2'h1
`define CRTS_MODE_RUN 2'h2

// Scene fields and limits
`define CRTS_SCENE_MAX 4'h9
`define CRTS_SCENE_DEF 4'h0

// Interrupt bits
`define CRTS_IRQ_OK 0
`define CRTS_IRQ_NG 1
`define CRTS_IRQ_W 2

// Serial message codes
`define CRTS_ERR_CODE 8'hEE
`define CRTS_OK_CODE 8'hAA

`endif

// ==== hdl/crts_top.v ====
// Trigger sequencer of the code reader: triggers, retries, judgement, serial report
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "crts_defines.vh"

module crts_top (
  input wire clock_i,
  input wire rstn_i,
  input wire one_shot_trigger_i,
  input wire hold_read_trigger_i,
  input wire scene_switch_trigger_first_i,
  input wire scene_switch_trigger_second_i,
  input wire read_done_i,
  input wire read_ok_i,
  input wire [7:0] decode_data_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  output reg shutter_o,
  output reg [3:0] scene_o,
  output reg busy_o,
  output reg run_o,
  output reg judgement_output_o,
  output reg result_valid_o,
  output reg tx_valid_o,
  output reg [7:0] tx_data_o,
  output reg tx_is_error_o,
  output reg irq_o
);

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_s1_q;
  reg rst_s2_q;
  wire rstn;

  // The pin may rise at any moment; the two flops make the release
  // land on a clock edge, so no flop sees it in the middle of setup.
  // Assertion stays asynchronous so a stopped clock still clears outputs.
  // Release reset through two flops so every flop leaves reset together
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rstn = rst_s2_q;

  // ****************************************
  // Trigger synchronisers
  // ****************************************
  reg [3:0] trig_s1_q;
  reg [3:0] trig_s2_q;
  reg [3:0] trig_prev_q;
  wire [3:0] trig_rise;

  // Trigger pins come from sensors and switches with no relation to
  // our clock. Two stages cost two cycles of latency on every trigger,
  // far below the shortest legal pulse, and keep metastable values
  // away from the edge detector.
  // The edge register resets low, the idle level of the pins, so
  // leaving reset never shows a false rising edge.
  // Pins are asynchronous; first stage is read by second stage only
  always @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      trig_s1_q <= 4'h0;
      trig_s2_q <= 4'h0;
      trig_prev_q <= 4'h0;
    end else begin
      trig_s1_q <= {scene_switch_trigger_second_i, scene_switch_trigger_first_i,
                    hold_read_trigger_i, one_shot_trigger_i}; // [R19]
      trig_s2_q <= trig_s1_q; // [R19]
      trig_prev_q <= trig_s2_q;
    end
  end
  assign trig_rise = trig_s2_q & ~trig_prev_q;

  // ****************************************
  // Registers
  // ****************************************
  reg [1:0] mode_q;
  reg hold_lvl_q;
  reg pol_ok_q;
  reg [3:0] retry_q;
  reg [3:0] scene_a_q;
  reg [3:0] scene_b_q;
  reg [3:0] scene_cur_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg [1:0] irq_set_q;
  wire active_mode;
  wire run_mode;

  // Control word: mode, hold behaviour, judgement polarity, retry count.
  // Writes take effect on the next edge; a mode change in the middle of
  // a reading lets that reading finish, and only its result is gated.
  // Limit a written scene to the legal range
  function [3:0] clip_scene;
    input [3:0] s;
    begin
      clip_scene = (s > `CRTS_SCENE_MAX) ? `CRTS_SCENE_MAX : s; // [R16]
    end
  endfunction

  assign active_mode = (mode_q == `CRTS_MODE_MON) || (mode_q == `CRTS_MODE_RUN);
  assign run_mode = (mode_q == `CRTS_MODE_RUN);

  // Unmapped offsets are ignored; scene values above the limit are
  // stored as the limit rather than wrapped
  // Configuration writes
  always @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      mode_q <= `CRTS_MODE_SETUP;
      hold_lvl_q <= 1'b0;
      pol_ok_q <= 1'b0; // [R15]
      retry_q <= 4'h0;
      scene_a_q <= `CRTS_SCENE_DEF; // [R16]
      scene_b_q <= `CRTS_SCENE_DEF; // [R16]
      irq_mask_q <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        `CRTS_REG_CTRL: begin
          mode_q <= wdata_i[`CRTS_CTRL_MODE_HI:`CRTS_CTRL_MODE_LO];
          hold_lvl_q <= wdata_i[`CRTS_CTRL_HOLD_LVL];
          pol_ok_q <= wdata_i[`CRTS_CTRL_POL_OK];
          retry_q <= wdata_i[`CRTS_CTRL_RETRY_HI:`CRTS_CTRL_RETRY_LO];
        end
        `CRTS_REG_SCENE: begin
          scene_a_q <= clip_scene(wdata_i[3:0]);
          scene_b_q <= clip_scene(wdata_i[7:4]);
        end
        `CRTS_REG_IRQ_MASK: irq_mask_q <= wdata_i[`CRTS_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Write one to clear. An event arriving in the clearing cycle stays
  // set, so software never loses a result it has not yet seen.
  // Sticky events; a set in the clear cycle wins
  always @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      if (wr_i && addr_i == `CRTS_REG_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~wdata_i[`CRTS_IRQ_W-1:0]) | irq_set_q;
      else
        irq_stat_q <= irq_stat_q | irq_set_q;
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Zero outside the read cycle keeps stale data off the bus
  // Read data one cycle after the strobe, zero otherwise
  always @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        `CRTS_REG_CTRL: rdata_o <= {24'h0, retry_q, pol_ok_q, hold_lvl_q, mode_q};
        `CRTS_REG_SCENE: rdata_o <= {24'h0, scene_b_q, scene_a_q};
        `CRTS_REG_STATUS: rdata_o <= {24'h0, trig_s2_q, scene_cur_q};
        `CRTS_REG_IRQ_STAT: rdata_o <= {30'h0, irq_stat_q};
        `CRTS_REG_IRQ_MASK: rdata_o <= {30'h0, irq_mask_q};
        `CRTS_REG_RESULT: rdata_o <= {23'h0, judgement_output_o, tx_data_o};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // ****************************************
  // Reading sequencer
  // ****************************************
  // IDLE waits for a trigger, READ fires the shutter, WAIT holds until
  // the reader engine reports, DONE hands the result on and either
  // starts the next continuous reading or returns to idle.
  // Busy stays high from the first shutter to the end of DONE, so
  // triggers in between never reach the decision in idle.
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_DONE = 2'h3;

  localparam SRC_ONE = 2'h0;
  localparam SRC_CONT = 2'h1;
  localparam SRC_LVL = 2'h2;

  // Which pin owns a level reading
  localparam HOLD_B = 2'h0;
  localparam HOLD_C = 2'h2;
  localparam HOLD_D = 2'h3;

  reg [1:0] state_q;
  reg [1:0] src_q;
  reg [3:0] tries_q;
  reg pass_q;
  reg [7:0] data_q;
  reg [1:0] hold_bit_q;
  wire held;

  // A scene trigger keeps its own pin as the hold level, so releasing
  // it ends a failing level reading just as the hold pin does
  // Which trigger keeps a level reading alive
  assign held = hold_bit_q[1] ? (hold_bit_q[0] ? trig_s2_q[3] : trig_s2_q[2]) : trig_s2_q[1];

  // One reading is in flight at a time; triggers are never queued
  // Main sequencer; trigger edges are only looked at in idle, so busy masks them
  always @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      src_q <= SRC_ONE;
      tries_q <= 4'h0;
      pass_q <= 1'b0;
      data_q <= 8'h0;
      hold_bit_q <= 2'h0;
      scene_cur_q <= `CRTS_SCENE_DEF;
      shutter_o <= 1'b0;
      busy_o <= 1'b0;
      irq_set_q <= 2'h0;
    end else begin
      shutter_o <= 1'b0;
      irq_set_q <= 2'h0;
      case (state_q)
        ST_IDLE: begin
          busy_o <= 1'b0;
          tries_q <= 4'h0;
          pass_q <= 1'b0;
          if (active_mode) begin // [R1]
            // One-shot fires the shutter on the edge it is seen, so the
            // image is taken as close to the trigger as possible
            if (trig_rise[0]) begin
              src_q <= SRC_ONE; // [R2]
              shutter_o <= 1'b1; // [R14]
              busy_o <= 1'b1; // [R18]
              state_q <= ST_WAIT;
            end else if (trig_rise[2] || trig_rise[3]) begin
              scene_cur_q <= trig_rise[2] ? scene_a_q : scene_b_q; // [R8]
              hold_bit_q <= trig_rise[2] ? HOLD_C : HOLD_D;
              src_q <= SRC_LVL; // [R16]
              busy_o <= 1'b1;
              state_q <= ST_READ;
            // Level mode needs a fresh press: a success must not be
            // followed by another reading while the trigger stays held
            end else if (trig_s2_q[1] && (!hold_lvl_q || trig_rise[1])) begin // [R6]
              hold_bit_q <= HOLD_B;
              src_q <= hold_lvl_q ? SRC_LVL : SRC_CONT;
              busy_o <= 1'b1; // [R18]
              state_q <= ST_READ;
            end
          end
        end
        ST_READ: begin
          shutter_o <= 1'b1;
          state_q <= ST_WAIT;
        end
        // A one-shot retries until its count is used up; continuous
        // reports every reading; level keeps trying while held
        ST_WAIT: begin
          if (read_done_i) begin
            data_q <= decode_data_i;
            if (src_q == SRC_ONE) begin
              if (read_ok_i || tries_q == retry_q) begin // [R3] [R4]
                pass_q <= read_ok_i;
                state_q <= ST_DONE;
              end else begin
                tries_q <= tries_q + 4'h1; // [R4]
                state_q <= ST_READ;
              end
            end else if (src_q == SRC_CONT) begin
              pass_q <= read_ok_i; // [R5] [R17]
              state_q <= ST_DONE;
            end else if (read_ok_i) begin
              pass_q <= 1'b1; // [R6]
              state_q <= ST_DONE;
            end else if (!held) begin
              pass_q <= 1'b0; // [R7]
              state_q <= ST_DONE;
            end else begin
              state_q <= ST_READ; // [R6] [R17]
            end
          end
        end
        // Result and event in the cycle after the last reading
        ST_DONE: begin
          irq_set_q <= pass_q ? 2'h1 : 2'h2; // [R10]
          if (src_q == SRC_CONT && trig_s2_q[1] && active_mode)
            state_q <= ST_READ; // [R5]
          else begin
            busy_o <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Result outputs
  // ****************************************
  // The judgement is a level that stands until the next result, so a
  // host sampling late still sees it; leaving run mode drops it at once.
  // The serial byte carries decoded data on success and the error code
  // on failure, flagged so the host can tell the two apart.
  // Judgement, result and serial outputs only leave the block in run mode; all low after reset
  always @(posedge clock_i or negedge rstn) begin
    if (!rstn) begin
      judgement_output_o <= 1'b0; // [R13]
      result_valid_o <= 1'b0; // [R13]
      tx_valid_o <= 1'b0; // [R13]
      tx_data_o <= 8'h0;
      tx_is_error_o <= 1'b0;
      scene_o <= `CRTS_SCENE_DEF;
      run_o <= 1'b0;
    end else begin
      run_o <= run_mode;
      scene_o <= scene_cur_q;
      result_valid_o <= 1'b0;
      tx_valid_o <= 1'b0;
      if (!run_mode) begin
        judgement_output_o <= 1'b0; // [R9]
      end else if (state_q == ST_DONE) begin
        result_valid_o <= 1'b1; // [R10]
        judgement_output_o <= pass_q ~^ pol_ok_q ? 1'b1 : 1'b0; // [R15]
        tx_valid_o <= 1'b1;
        tx_data_o <= pass_q ? data_q : `CRTS_ERR_CODE; // [R11] [R12]
        tx_is_error_o <= ~pass_q; // [R12]
      end
    end
  end

endmodule // crts_top

`default_nettype wire

// ==== verif/crts_monitor.sv ====
// Port checker for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
`include "crts_defines.vh"
// ****
// Checker
// ****
module crts_monitor (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic read_done_i,
  input wire logic shutter_o,
  input wire logic [3:0] scene_o,
  input wire logic busy_o,
  input wire logic run_o,
  input wire logic judgement_output_o,
  input wire logic result_valid_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_is_error_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_shut_busy: assert property (shutter_o |-> busy_o)
    else $error("capture outside busy");
  a_shut_pulse: assert property (shutter_o |=> !shutter_o)
    else $error("capture longer than one cycle");
  a_res_run: assert property (result_valid_o |-> run_o)
    else $error("result outside run mode");
  // One cycle of slack when run mode is left
  a_judge_off: assert property (!run_o ##1 !run_o |-> !judgement_output_o)
    else $error("judgement outside run mode");
  a_res_cause: assert property (result_valid_o |-> $past(read_done_i, 2))
    else $error("result without a finished reading");
  a_tx_pair: assert property (tx_valid_o |-> result_valid_o)
    else $error("serial byte without result");
  a_err_code: assert property (tx_valid_o && tx_is_error_o |-> tx_data_o == `CRTS_ERR_CODE)
    else $error("wrong error code");
  a_scene_max: assert property (scene_o <= `CRTS_SCENE_MAX)
    else $error("scene above limit");
endmodule // crts_monitor
bind crts_top crts_monitor i_mon (.clock_i, .rstn_i, .read_done_i, .shutter_o, .scene_o,
  .busy_o, .run_o, .judgement_output_o, .result_valid_o, .tx_valid_o, .tx_data_o,
  .tx_is_error_o);
`default_nettype wire

// ==== verif/crts_reader_model.sv ====
// Reader engine model: answers each capture after a fixed delay
`timescale 1ns/1ps
`default_nettype none
// ****
// Reader
// ****
module crts_reader_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic shutter_i,
  input wire logic ok_i,
  input wire logic [7:0] byte_i,
  output logic done_o,
  output logic ok_o,
  output logic [7:0] data_o
);
  int cnt = 0;
  // Done only after a capture; lines churn between answers so stale values never pass
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
      ok_o <= 1'b0;
      data_o <= 8'h00;
      cnt <= 0;
    end else begin
      done_o <= 1'b0;
      ok_o <= ~ok_o;
      data_o <= data_o + 8'h01;
      if (shutter_i) cnt <= 30;
      else if (cnt > 0) cnt <= cnt - 1;
      if (!shutter_i && cnt == 1) begin
        done_o <= 1'b1;
        ok_o <= ok_i;
        data_o <= byte_i;
      end
    end
  end
endmodule // crts_reader_model
`default_nettype wire

// ==== verif/crts_top_tb.sv ====
// Self-checking testbench of the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
`include "crts_defines.vh"
module crts_top_tb;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] trig = 4'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ok = 1'b1;
  logic [7:0] last_tx = 8'h00;
  logic last_err = 1'b0;
  wire logic done, rok, shut, busy, run, judge, resv, txv, txe, irq;
  wire logic [7:0] ddata, txd;
  wire logic [3:0] scene;
  wire logic [31:0] rdata;
  int errors = 0;
  int checks_done = 0;
  int shots = 0;
  int s = 0;
  int results = 0;
  int r = 0;
  initial forever #20 clock_i = ~clock_i;
  // Tally captures and keep the last serial byte
  always @(posedge clock_i) begin
    shots <= shots + shut;
    results <= results + resv;
    if (txv) last_tx <= txd;
    if (txv) last_err <= txe;
  end
  crts_top i_dut (.clock_i, .rstn_i, .one_shot_trigger_i(trig[0]),
    .hold_read_trigger_i(trig[1]), .scene_switch_trigger_first_i(trig[2]),
    .scene_switch_trigger_second_i(trig[3]), .read_done_i(done), .read_ok_i(rok),
    .decode_data_i(ddata), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .shutter_o(shut), .scene_o(scene), .busy_o(busy), .run_o(run),
    .judgement_output_o(judge), .result_valid_o(resv), .tx_valid_o(txv), .tx_data_o(txd),
    .tx_is_error_o(txe), .irq_o(irq));
  crts_reader_model i_rdr (.clock_i, .rstn_i, .shutter_i(shut), .ok_i(ok), .byte_i(8'h5A),
    .done_o(done), .ok_o(rok), .data_o(ddata));
  // ****
  // Helpers
  // ****
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    checks_done++;
    if (v !== e) begin
      errors++;
      $display("Error %s expected %0h seen %0h", n, e, v);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(negedge clock_i);
    chk(n, e, rdata);
  endtask
  // Bounded wait for the reading to finish
  task automatic settle;
    int i;
    repeat (6) @(posedge clock_i);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clock_i);
    repeat (4) @(posedge clock_i);
  endtask
  task automatic fire(input logic [3:0] t, input int hold);
    @(posedge clock_i);
    s = shots;
    r = results;
    trig <= t;
    repeat (hold) @(posedge clock_i);
    trig <= 4'h0;
    settle;
  endtask
  task automatic wrap_up;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    chk("outputs", 32'h0, {shut, busy, run, judge, resv, txv, irq, txe, scene, txd});
    rd_chk("ctrl", `CRTS_REG_CTRL, 32'h0);
    rd_chk("unmapped", 4'hF, 32'h0);
  endtask
  task automatic t_modes;
    wr_reg(`CRTS_REG_CTRL, 32'h0);
    fire(4'h1, 4);
    chk("setup shots", 0, shots - s);
    wr_reg(`CRTS_REG_CTRL, 32'h1);
    fire(4'h1, 4);
    chk("mon shots", 1, shots - s);
    chk("mon tx", 8'h00, last_tx);
    chk("mon results", 0, results - r);
  endtask
  // Second edge lands while busy and must leave no trace
  task automatic t_one;
    wr_reg(`CRTS_REG_CTRL, 32'h32);
    wr_reg(`CRTS_REG_IRQ_MASK, 32'h3);
    wr_reg(`CRTS_REG_IRQ_STAT, 32'h3);
    ok <= 1'b1;
    @(posedge clock_i);
    s = shots;
    trig <= 4'h1;
    repeat (10) @(posedge clock_i);
    trig <= 4'h0;
    repeat (4) @(posedge clock_i);
    trig <= 4'h1;
    settle;
    trig <= 4'h0;
    chk("one shots", 1, shots - s);
    chk("run level", 1'b1, run);
    chk("one judge", 1'b0, judge);
    chk("one tx", 9'h05A, {last_err, last_tx});
    chk("irq set", 1'b1, irq);
    rd_chk("irq stat", `CRTS_REG_IRQ_STAT, 32'h1);
    wr_reg(`CRTS_REG_IRQ_STAT, 32'h3);
    settle;
    chk("irq clear", 1'b0, irq);
  endtask
  task automatic t_retry;
    wr_reg(`CRTS_REG_CTRL, 32'h22);
    ok <= 1'b0;
    fire(4'h1, 4);
    chk("retry shots", 3, shots - s);
    chk("fail judge", 1'b1, judge);
    chk("fail tx", {1'b1, `CRTS_ERR_CODE}, {last_err, last_tx});
    rd_chk("result reg", `CRTS_REG_RESULT, {23'h0, 1'b1, `CRTS_ERR_CODE});
    wr_reg(`CRTS_REG_CTRL, 32'h0A);
    ok <= 1'b1;
    fire(4'h1, 4);
    chk("pol judge", 1'b1, judge);
  endtask
  task automatic t_hold;
    wr_reg(`CRTS_REG_CTRL, 32'h32);
    ok <= 1'b0;
    fire(4'h2, 200);
    chk("cont shots", 1, (shots - s) >= 4);
    chk("cont results", shots - s, results - r);
    s = shots;
    repeat (100) @(posedge clock_i);
    chk("cont stop", 0, shots - s);
    wr_reg(`CRTS_REG_CTRL, 32'h06);
    ok <= 1'b1;
    fire(4'h2, 200);
    chk("level ok shots", 1, shots - s);
    ok <= 1'b0;
    fire(4'h2, 100);
    chk("level fail", 2'h3, {judge, last_err});
  endtask
  task automatic t_scene;
    wr_reg(`CRTS_REG_SCENE, 32'hC3);
    rd_chk("scene reg", `CRTS_REG_SCENE, 32'h93);
    wr_reg(`CRTS_REG_CTRL, 32'h02);
    ok <= 1'b1;
    fire(4'h4, 4);
    chk("scene first", 4'h3, scene);
    chk("scene read", 1, shots - s);
    fire(4'h8, 4);
    chk("scene clip", `CRTS_SCENE_MAX, scene);
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    t_reset;
    t_modes;
    t_one;
    t_retry;
    t_hold;
    t_scene;
    wrap_up;
  end
  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    errors++;
    wrap_up;
  end
endmodule // crts_top_tb
`default_nettype wire
